// file: rtl/adc_fifo_config_sequencer.sv
// Purpose: register side and channel/result queues of the converter
// Assumes: AXI4-Lite master, at most one write and one read at a time
// Notes: converter clock runs at most at half the bus clock
`timescale 1ns/1ps
`default_nettype none
module adc_fifo_config_sequencer #(
  parameter int QUEUE_MAX = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side
  input wire logic hw_trigger,
  input wire logic [11:0] ain_code,
  input wire logic ain_at_high,
  input wire logic ain_at_low,
  output logic [4:0] ain_select,
  output logic sample_active,
  output logic converter_clock,
  output logic [15:0] pin_digital_disable,
  // interrupt
  output logic irq
);
  import adc_seq_pkg::*;

  generate
    if (QUEUE_MAX != 8) begin : g_bad_depth
      $error("queue storage is built for exactly eight entries");
    end
  endgenerate

  seq_state_type s_r, s_nxt;
  conv_link_if u_link();
  logic half_tick;
  logic [3:0] depth;
  logic [3:0] eff_depth;
  logic queued;
  logic scan;
  logic [11:0] head;
  logic [31:0] wv;
  logic [31:0] rv;
  logic rd_ok;
  logic [4:0] start_chan;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  assign depth = {1'b0, s_r.qc[`QC_DEPTH_LSB +: 3]};
  assign queued = (depth != 4'h0);
  assign eff_depth = queued ? depth : 4'h1;
  assign scan = queued && s_r.qc[`QC_SCAN_BIT];
  assign head = s_r.resq[s_r.res_rd];
  assign start_chan = scan ? s_r.chq[0] : s_r.chq[s_r.idx[2:0]];

  // read mux, shared by the read handshake
  always_comb begin
    rv = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFF_CHANNEL_CONTROL: rv = {24'h0, s_r.conversion_complete_flag, s_r.ccw[6:5], u_link.channel};
      `OFF_TRIGGER_COMPARE: rv = {24'h0, s_r.tcc};
      `OFF_CLOCK_SAMPLE: rv = {24'h0, s_r.csc};
      `OFF_QUEUE_CONFIG: rv = {24'h0, s_r.qc};
      `OFF_RESULT: rv = {16'h0, 4'h0, head};
      `OFF_RESULT_HIGH: rv = {24'h0, 4'h0, head[11:8]};
      `OFF_RESULT_LOW: rv = {24'h0, head[7:0]};
      `OFF_PIN_CONTROL: rv = {16'h0, s_r.pins};
      `OFF_IRQ_STATUS: rv = {31'h0, s_r.irq_stat};
      `OFF_IRQ_MASK: rv = {31'h0, s_r.irq_mask};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.abort = 1'b0;
    wv = merge(32'h0, s_r.w_data, s_r.w_strb);

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_pend = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_pend = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel; result pop and flag clear happen on the address handshake
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv;
      s_nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (s_axi_araddr == `OFF_RESULT) begin
        s_nxt.conversion_complete_flag = 1'b0;
        if (queued) begin
          s_nxt.res_rd = s_r.res_rd + 3'h1;
        end
      end
    end

    // conversion finished: store result, advance, flag at the end
    if (u_link.done && s_r.inflight) begin
      s_nxt.inflight = 1'b0;
      s_nxt.resq[s_r.res_cnt[2:0]] = u_link.result;
      s_nxt.res_cnt = s_r.res_cnt + 4'h1;
      s_nxt.idx = s_r.idx + 4'h1;
      if (s_r.idx + 4'h1 == eff_depth) begin
        s_nxt.conversion_complete_flag = 1'b1;
        s_nxt.irq_stat = s_r.irq_stat | s_r.ccw[`CCW_COMPLETE_INTERRUPT_ENABLE_BIT];
        s_nxt.idx = 4'h0;
        s_nxt.res_rd = 3'h0;
        if (s_r.ccw[`CCW_CONT_BIT]) begin
          s_nxt.res_cnt = 4'h0;
        end else begin
          s_nxt.busy = 1'b0;
        end
      end
    end

    // issue the next conversion; hardware trigger gates every one
    if (s_r.busy && !s_r.inflight && !u_link.busy && !s_r.start) begin
      if (!s_r.tcc[`TCC_HWTRIG_BIT] || hw_trigger) begin
        s_nxt.start = 1'b1;
        s_nxt.inflight = 1'b1;
      end
    end

    // register writes
    if (s_r.aw_pend && s_r.w_pend && !s_r.bvalid) begin
      s_nxt.aw_pend = 1'b0;
      s_nxt.w_pend = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `RESP_OKAY;
      case (s_r.aw_addr)
        `OFF_CHANNEL_CONTROL: begin
          if (s_r.w_strb[0]) begin
            s_nxt.ccw = wv[6:0];
            // a write while running or after a full fill restarts the queue
            if (s_r.busy || s_r.chq_cnt >= eff_depth) begin
              s_nxt.abort = s_r.inflight;
              s_nxt.inflight = 1'b0;
              s_nxt.start = 1'b0;
              s_nxt.busy = 1'b0;
              s_nxt.chq_cnt = 4'h1;
              s_nxt.chq[0] = wv[4:0];
            end else begin
              s_nxt.chq[s_r.chq_cnt[2:0]] = wv[4:0];
              s_nxt.chq_cnt = s_r.chq_cnt + 4'h1;
            end
            // conversions begin once the queue is filled, or on every such write in scan mode
            if (scan || s_nxt.chq_cnt == eff_depth) begin
              s_nxt.busy = 1'b1;
              s_nxt.idx = 4'h0;
              s_nxt.res_cnt = 4'h0;
              s_nxt.res_rd = 3'h0;
              s_nxt.conversion_complete_flag = 1'b0;
            end
          end
        end
        `OFF_TRIGGER_COMPARE: s_nxt.tcc = wv[7:0];
        `OFF_CLOCK_SAMPLE: s_nxt.csc = wv[7:0];
        `OFF_QUEUE_CONFIG: begin
          s_nxt.qc = wv[7:0];
          s_nxt.chq_cnt = 4'h0;
        end
        `OFF_PIN_CONTROL: s_nxt.pins = 16'(merge({16'h0, s_r.pins}, s_r.w_data,
                                             s_r.w_strb));
        `OFF_IRQ_STATUS: begin
          // set from a completion in this cycle wins over the clear
          if (wv[0] && !(u_link.done && s_r.inflight && s_r.idx + 4'h1 == eff_depth)) begin
            s_nxt.irq_stat = 1'b0;
          end
        end
        `OFF_IRQ_MASK: s_nxt.irq_mask = wv[0];
        default: s_nxt.bresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // link to the engine
  assign u_link.start = s_r.start;
  assign u_link.abort = s_r.abort;
  assign u_link.channel = s_r.busy ? start_chan : s_r.ccw[4:0];
  assign u_link.long_sample = s_r.csc[`CSC_LSMP_BIT];
  assign u_link.res_mode = s_r.csc[`CSC_MODE_LSB +: 2];

  conv_clock_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_half(s_r.csc[`CSC_SRC_BIT]),
    .div_code(s_r.csc[`CSC_DIV_LSB +: 2]),
    .half_tick(half_tick),
    .conv_clk(converter_clock)
  );

  conv_engine u_eng (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_tick(half_tick),
    .link(u_link.core),
    .ain_code(ain_code),
    .ain_at_high(ain_at_high),
    .ain_at_low(ain_at_low),
    .ain_select(ain_select),
    .sample_active(sample_active)
  );

  // bus handshakes
  assign s_axi_awready = !s_r.aw_pend && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_pend && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  assign pin_digital_disable = s_r.pins;
  assign irq = s_r.irq_stat & s_r.irq_mask;
endmodule : adc_fifo_config_sequencer
`default_nettype wire

// file: rtl/adc_seq_consts.svh
// Purpose: offsets, fields, resets and counts of the converter sequencer
// Assumes: 32-bit register words at aligned byte addresses
// Notes: included by its bare name
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define OFF_CHANNEL_CONTROL 8'h00
`define OFF_TRIGGER_COMPARE 8'h04
`define OFF_CLOCK_SAMPLE 8'h08
`define OFF_QUEUE_CONFIG 8'h0C
`define OFF_RESULT 8'h10
`define OFF_RESULT_HIGH 8'h14
`define OFF_RESULT_LOW 8'h18
`define OFF_PIN_CONTROL 8'h1C
`define OFF_IRQ_STATUS 8'h20
`define OFF_IRQ_MASK 8'h24
// channel_control_word
`define CCW_CHAN_LSB 0
`define CCW_CONT_BIT 5
`define CCW_COMPLETE_INTERRUPT_ENABLE_BIT 6
`define CCW_CONVERSION_COMPLETE_FLAG_BIT 7
// trigger_compare_control
`define TCC_HWTRIG_BIT 6
// clock_sample_config
`define CSC_SRC_BIT 0
`define CSC_MODE_LSB 2
`define CSC_LSMP_BIT 4
`define CSC_DIV_LSB 5
`define CSC_LPC_BIT 7
// queue_config
`define QC_DEPTH_LSB 0
`define QC_COMPARE_AND_OR_SELECT_BIT 5
`define QC_SCAN_BIT 6
// resolution codes
`define RES_8 2'h0
`define RES_12 2'h1
`define RES_10 2'h2
`define FULL_12 12'hFFF
`define FULL_10 12'h3FF
`define FULL_8 12'h0FF
`define ZERO_CODE 12'h000
// sample window in half converter-clock periods (3.5 and 23.5 cycles)
`define SAMPLE_SHORT_HALVES 7'h07
`define SAMPLE_LONG_HALVES 7'h2F
`define RESET_BYTE 8'h00
`define RESET_PINS 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: rtl/adc_seq_pkg.sv
// Purpose: types shared by the converter sequencer modules
// Assumes: constants come from adc_seq_consts.svh
// Notes: queue depth fixed at eight entries
`include "adc_seq_consts.svh"
package adc_seq_pkg;
  typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_CONVERT} conv_state_type;
  typedef struct packed {
    conv_state_type st;
    logic [6:0] cnt;
    logic [4:0] chan;
    logic long_smp;
    logic [1:0] mode;
    logic hi;
    logic lo;
    logic [11:0] code;
    logic done;
    logic [11:0] result;
  } core_state_type;
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
    logic clk;
  } div_state_type;
  typedef struct packed {
    logic aw_pend;
    logic [7:0] aw_addr;
    logic w_pend;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] ccw;
    logic conversion_complete_flag;
    logic [7:0] tcc;
    logic [7:0] csc;
    logic [7:0] qc;
    logic [15:0] pins;
    logic irq_stat;
    logic irq_mask;
    logic [7:0][4:0] chq;
    logic [3:0] chq_cnt;
    logic [3:0] idx;
    logic [7:0][11:0] resq;
    logic [3:0] res_cnt;
    logic [2:0] res_rd;
    logic busy;
    logic inflight;
    logic start;
    logic abort;
  } seq_state_type;
endpackage : adc_seq_pkg

// file: rtl/conv_clock_divider.sv
// Purpose: derives the converter clock from the bus clock
// Assumes: ratio and source change only while idle
// Notes: tick marks each half period of the converter clock
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration
  input wire logic src_half,
  input wire logic [1:0] div_code,
  // derived clock
  output logic half_tick,
  output logic conv_clk
);
  import adc_seq_pkg::*;
  div_state_type s_r, s_nxt;
  logic [4:0] half_len;

  // ratio 1,2,4,8; the slower source doubles it
  assign half_len = 5'((5'h01 << div_code) << src_half);

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= half_len - 5'h01) begin
      s_nxt.cnt = 5'h00;
      s_nxt.tick = 1'b1;
      s_nxt.clk = ~s_r.clk;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign half_tick = s_r.tick;
  assign conv_clk = s_r.clk;
endmodule : conv_clock_divider
`default_nettype wire

// file: rtl/conv_engine.sv
// Purpose: sample and approximation timing of one conversion
// Assumes: analog front end presents an ideal 12-bit code and limit flags
// Notes: abort returns to idle without a done pulse
`timescale 1ns/1ps
`default_nettype none
module conv_engine (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic half_tick,
  // sequencer link
  conv_link_if.core link,
  // analog front end
  input wire logic [11:0] ain_code,
  input wire logic ain_at_high,
  input wire logic ain_at_low,
  output logic [4:0] ain_select,
  output logic sample_active
);
  import adc_seq_pkg::*;
  core_state_type s_r, s_nxt;
  logic [6:0] samp_len;
  logic [6:0] conv_len;
  logic [11:0] full;
  logic [11:0] scaled;

  assign samp_len = s_r.long_smp ? `SAMPLE_LONG_HALVES : `SAMPLE_SHORT_HALVES;

  always_comb begin
    case (s_r.mode)
      `RES_12: begin
        full = `FULL_12;
        scaled = s_r.code;
        conv_len = 7'd24;
      end
      `RES_10: begin
        full = `FULL_10;
        scaled = {2'h0, s_r.code[11:2]};
        conv_len = 7'd20;
      end
      default: begin
        full = `FULL_8;
        scaled = {4'h0, s_r.code[11:4]};
        conv_len = 7'd16;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      CONV_IDLE: begin
        if (link.start) begin
          s_nxt.st = CONV_SAMPLE;
          // armed until the next tick, so the window spans whole half periods
          s_nxt.cnt = 7'h7F;
          s_nxt.chan = link.channel;
          s_nxt.long_smp = link.long_sample;
          s_nxt.mode = link.res_mode;
        end
      end
      CONV_SAMPLE: begin
        if (half_tick) begin
          s_nxt.cnt = s_r.cnt + 7'h01;
          if (s_r.cnt == samp_len - 7'h01) begin
            s_nxt.st = CONV_CONVERT;
            s_nxt.cnt = 7'h00;
            s_nxt.code = ain_code;
            s_nxt.hi = ain_at_high;
            s_nxt.lo = ain_at_low;
          end
        end
      end
      CONV_CONVERT: begin
        if (half_tick) begin
          s_nxt.cnt = s_r.cnt + 7'h01;
          if (s_r.cnt == conv_len - 7'h01) begin
            s_nxt.st = CONV_IDLE;
            s_nxt.done = 1'b1;
            if (s_r.hi) begin
              s_nxt.result = full;
            end else if (s_r.lo) begin
              s_nxt.result = `ZERO_CODE;
            end else begin
              s_nxt.result = scaled;
            end
          end
        end
      end
      default: begin
        s_nxt.st = CONV_IDLE;
      end
    endcase
    if (link.abort) begin
      s_nxt.st = CONV_IDLE;
      s_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.busy = (s_r.st != CONV_IDLE);
  assign link.done = s_r.done;
  assign link.result = s_r.result;
  assign ain_select = s_r.chan;
  assign sample_active = (s_r.st == CONV_SAMPLE) && (s_r.cnt != 7'h7F);
endmodule : conv_engine
`default_nettype wire

// file: rtl/conv_link_if.sv
// Purpose: link between the sequencer and the conversion engine
// Assumes: single clock domain
// Notes: start and abort are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
  logic start;
  logic abort;
  logic [4:0] channel;
  logic long_sample;
  logic [1:0] res_mode;
  logic busy;
  logic done;
  logic [11:0] result;
  modport ctl(output start, abort, channel, long_sample, res_mode,
    input busy, done, result);
  modport core(input start, abort, channel, long_sample, res_mode,
    output busy, done, result);
endinterface : conv_link_if
`default_nettype wire

// file: test/adc_fifo_config_sequencer_tb.sv
// Purpose: register-level tests of the converter sequencer
// Assumes: converter clock derived from the 200 MHz bus clock
// Notes: analog side comes from analog_source_model
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"
bind adc_fifo_config_sequencer adc_seq_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rresp, .s_axi_rdata, .sample_active, .ain_select, .irq);
module adc_fifo_config_sequencer_tb;
  logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ain_at_high, ain_at_low, sample_active, converter_clock, irq;
  logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hw_trigger = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] level_mode = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [11:0] ain_code;
  logic [4:0] ain_select;
  logic [15:0] pin_digital_disable;
  int fail_count, total_checks, cycles, run_len, last_width, starts;
  logic [7:0] t_cfg [7] = '{8'h04, 8'h38, 8'h00, 8'h04, 8'h01, 8'h08, 8'h08};
  logic [1:0] t_lvl [7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [4:0] t_ch [7] = '{5'h03, 5'h03, 5'h03, 5'h03, 5'h03, 5'h03, 5'h05};
  logic [11:0] t_res [7] = '{12'h1AA, 12'h3FF, 12'h0FF, 12'hFFF, 12'h000, 12'h000, 12'h0AA};
  int t_w [7] = '{7, 94, 7, 7, 14, 7, 7};

  adc_fifo_config_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_trigger,
    .ain_code, .ain_at_high, .ain_at_low, .ain_select, .sample_active, .converter_clock,
    .pin_digital_disable, .irq);
  analog_source_model model_u (.aclk, .ain_select, .sample_active, .level_mode, .ain_code,
    .ain_at_high, .ain_at_low);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // window width and start count measured at the pins, plus the hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (sample_active && run_len == 0) starts <= starts + 1;
    if (sample_active) run_len <= run_len + 1;
    else if (run_len != 0) last_width <= run_len;
    if (!sample_active) run_len <= 0;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // handshakes judged at the falling edge, where all is settled; drives move on the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = `RESP_OKAY);
    logic got, aw_go, w_go;
    logic [1:0] resp;
    got = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("write resp", e, resp);
  endtask : wr

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got, ar_go;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ar_go = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(n, e, d);
    chk("read resp", `RESP_OKAY, r);
  endtask : rd

  // polls the channel word; its read has no side effect on results
  task automatic wait_done();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    repeat (400) if (!d[7]) axi_read(`OFF_CHANNEL_CONTROL, d, r);
    chk("complete flag", 32'h1, {31'h0, d[7]});
  endtask : wait_done

  task automatic convert(input logic [7:0] cfg, input logic [4:0] ch, input logic [11:0] res,
      input int w);
    wr(`OFF_CLOCK_SAMPLE, {24'h0, cfg});
    wr(`OFF_QUEUE_CONFIG, 32'h0);
    wr(`OFF_TRIGGER_COMPARE, 32'h0);
    wr(`OFF_CHANNEL_CONTROL, {24'h0, 3'h2, ch});
    wait_done();
    chk("sample width", w, last_width);
    rd(`OFF_RESULT_HIGH, {28'h0, res[11:8]}, "high byte");
    rd(`OFF_RESULT_LOW, {24'h0, res[7:0]}, "low byte");
    rd(`OFF_RESULT, {20'h0, res}, "result");
    rd(`OFF_CHANNEL_CONTROL, {24'h0, 3'h2, ch}, "flag after read");
  endtask : convert

  task automatic note(input string n);
    $display("test %s done", n);
  endtask : note

  initial begin
    int s0;
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFF_CLOCK_SAMPLE, 32'h0, "clock config");
    rd(`OFF_QUEUE_CONFIG, 32'h0, "queue config");
    rd(`OFF_IRQ_MASK, 32'h0, "irq mask");
    axi_read(8'h30, d, r);
    chk("unmapped read", `RESP_SLVERR, r);
    wr(8'h30, 32'h5, `RESP_SLVERR);
    note("reset and map");
    for (int i = 0; i < 7; i++) begin
      level_mode <= t_lvl[i];
      convert(t_cfg[i], t_ch[i], t_res[i], t_w[i]);
    end
    note("single conversions");
    rd(`OFF_IRQ_STATUS, 32'h1, "irq status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    note("interrupt");
    wr(`OFF_CLOCK_SAMPLE, 32'h04);
    wr(`OFF_QUEUE_CONFIG, 32'h04);
    wr(`OFF_TRIGGER_COMPARE, 32'h0);
    level_mode <= 2'h0;
    s0 = starts;
    for (int k = 0; k < 3; k++) wr(`OFF_CHANNEL_CONTROL, 32'h41 + 2 * k);
    repeat (30) @(posedge aclk);
    chk("early start", s0, starts);
    chk("early irq", 32'h0, {31'h0, irq});
    wr(`OFF_CHANNEL_CONTROL, 32'h47);
    wait_done();
    chk("queued conversions", s0 + 4, starts);
    chk("queue irq", 32'h1, {31'h0, irq});
    for (int k = 0; k < 4; k++) rd(`OFF_RESULT, {20'h0, 5'(2 * k + 1), 7'h2A}, "queued");
    note("queue");
    wr(`OFF_QUEUE_CONFIG, 32'h44);
    wr(`OFF_TRIGGER_COMPARE, 32'h0);
    wr(`OFF_CHANNEL_CONTROL, 32'h43);
    wait_done();
    for (int k = 0; k < 4; k++) rd(`OFF_RESULT, 32'h1AA, "scan");
    note("scan");
    wr(`OFF_QUEUE_CONFIG, 32'h0);
    wr(`OFF_TRIGGER_COMPARE, 32'h40);
    s0 = starts;
    wr(`OFF_CHANNEL_CONTROL, 32'h42);
    repeat (30) @(posedge aclk);
    chk("trigger wait", s0, starts);
    hw_trigger <= 1'b1;
    wait_done();
    hw_trigger <= 1'b0;
    rd(`OFF_RESULT, 32'h12A, "triggered result");
    note("hardware trigger");
    wr(`OFF_PIN_CONTROL, 32'h00AA);
    @(posedge aclk);
    chk("pin disable", 32'h00AA, {16'h0, pin_digital_disable});
    rd(`OFF_PIN_CONTROL, 32'h00AA, "pin control");
    note("pin control");
    end_sim();
  end
endmodule : adc_fifo_config_sequencer_tb
`default_nettype wire

// file: test/adc_seq_monitor.sv
// Purpose: bus handshake and sample-window checks at the sequencer ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_seq_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // converter side
  input wire logic sample_active,
  input wire logic [4:0] ain_select,
  input wire logic irq
);
  logic [9:0] width_r;
  logic [9:0] width_nxt;
  always_comb begin
    width_nxt = sample_active ? width_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) width_r <= 10'h000;
    else width_r <= width_nxt;
  end
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken under response");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken under response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24
    |=> s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
  // width is 7 or 47 half periods, a half period being 1 to 16 bus cycles
  a_sample_width: assert property ($fell(sample_active) |->
    (width_r % 10'h007 == 10'h000 && width_r <= 10'h070)
    || (width_r % 10'h02F == 10'h000 && width_r <= 10'h2F0)) else $error("bad sample width");
  a_select_steady: assert property (sample_active ##1 sample_active |-> $stable(ain_select))
    else $error("channel moved while sampling");
  c_long_sample: cover property ($fell(sample_active) && width_r == 10'h05E);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
  c_irq: cover property ($rose(irq));
endmodule : adc_seq_monitor
`default_nettype wire

// file: test/analog_source_model.sv
// Purpose: ideal analog inputs in front of the converter
// Assumes: the engine looks at the code only inside the sample window
// Notes: outside the window and the cycle after it every line follows a noise counter that steps each cycle
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
  // clock
  input wire logic aclk,
  // converter side
  input wire logic [4:0] ain_select,
  input wire logic sample_active,
  // 0 plain code, 1 at high reference, 2 at low reference
  input wire logic [1:0] level_mode,
  output logic [11:0] ain_code,
  output logic ain_at_high,
  output logic ain_at_low
);
  logic live_r = 1'b0;
  logic [11:0] noise_r = 12'hA5A;
  logic live;
  always_ff @(posedge aclk) begin
    live_r <= sample_active;
    noise_r <= noise_r + 12'h3C7;
  end
  // held one cycle past the window in case the engine latches on its closing edge
  assign live = sample_active || live_r;
  assign ain_code = live ? {ain_select, 7'h2A} : noise_r;
  assign ain_at_high = live ? (level_mode == 2'h1) : noise_r[0];
  assign ain_at_low = live ? (level_mode == 2'h2) : noise_r[1];
endmodule : analog_source_model
`default_nettype wire
